// *** design/ccsr_irq_enc.sv ***
`default_nettype none
// prioritised source encoder, one code per variant family
module ccsr_irq_enc (
	input  wire ccsr_pkg::ccsr_irq_type i_pend,
	input  wire logic [5:0]             i_prog_rx,
	input  wire logic                   i_fifo_var,
	output logic [2:0]                  o_icode,
	output logic [4:0]                  o_eicode
);
	// error first, then wake, receive, transmit; only the winner shows
	always_comb begin
		o_icode = ccsr_pkg::IC_NONE;
		o_eicode = ccsr_pkg::EC_NONE;
		if (i_pend.err) begin // [R9]
			o_icode = ccsr_pkg::IC_ERR; // [R8]
			o_eicode = ccsr_pkg::EC_ERR; // [R11]
		end else if (i_pend.wake) begin
			o_icode = ccsr_pkg::IC_WAKE;
			o_eicode = ccsr_pkg::EC_WAKE;
		end else if (i_pend.rx0) begin
			o_icode = ccsr_pkg::IC_RX0;
			o_eicode = ccsr_pkg::EC_RX0;
		end else if (i_pend.rx1) begin
			o_icode = ccsr_pkg::IC_RX1;
			// fifo mode folds every receiver onto one code
			o_eicode = i_fifo_var ? ccsr_pkg::EC_RX0 : ccsr_pkg::EC_RX1; // [R13]
		end else if (i_pend.tx0) begin
			o_icode = ccsr_pkg::IC_TX0;
			o_eicode = ccsr_pkg::EC_TX0;
		end else if (i_pend.tx1) begin
			o_icode = ccsr_pkg::IC_TX1;
			o_eicode = ccsr_pkg::EC_TX1;
		end else if (i_pend.tx2) begin
			o_icode = ccsr_pkg::IC_TX2;
			o_eicode = ccsr_pkg::EC_TX2;
		end else begin
			// programmable buffers, lowest index first
			for (int i = 5; i >= 0; i--) begin
				if (i_pend.prog[i]) begin
					if (i_fifo_var && i_prog_rx[i]) begin
						o_eicode = ccsr_pkg::EC_RX0; // [R13]
					end else begin
						o_eicode = ccsr_pkg::EC_PRG0 + 5'(i); // [R12]
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** design/ccsr_pkg.sv ***
`default_nettype none
package ccsr_pkg;
	// register byte offsets on the apb slave
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] VAR_OFS  = 8'h08;

	// field positions inside the 8-bit registers
	localparam int REQ_LSB   = 5;
	localparam int ABORT_BIT = 4;
	localparam int WIN_LSB   = 1;
	localparam int VAR_LSB   = 0;

	// operating mode codes, requested and current
	localparam logic [2:0] MODE_NORMAL  = 3'h0;
	localparam logic [2:0] MODE_DISABLE = 3'h1;
	localparam logic [2:0] MODE_LOOP    = 3'h2;
	localparam logic [2:0] MODE_LISTEN  = 3'h3;
	localparam logic [2:0] MODE_CONFIG  = 3'h4;

	// reset values
	localparam logic [2:0] REQ_RST = 3'h4;
	localparam logic [2:0] CUR_RST = 3'h4;
	localparam logic [1:0] VAR_RST = 2'h0;
	localparam logic [2:0] WIN_RST = 3'h0;

	// operating variants
	localparam logic [1:0] VAR_LEGACY = 2'h0;
	localparam logic [1:0] VAR_ENH    = 2'h1;
	localparam logic [1:0] VAR_FIFO   = 2'h2;
	localparam logic [1:0] VAR_RSVD   = 2'h3;

	// legacy source codes
	localparam logic [2:0] IC_NONE = 3'h0;
	localparam logic [2:0] IC_ERR  = 3'h1;
	localparam logic [2:0] IC_TX2  = 3'h2;
	localparam logic [2:0] IC_TX1  = 3'h3;
	localparam logic [2:0] IC_TX0  = 3'h4;
	localparam logic [2:0] IC_RX1  = 3'h5;
	localparam logic [2:0] IC_RX0  = 3'h6;
	localparam logic [2:0] IC_WAKE = 3'h7;

	// enhanced source codes
	localparam logic [4:0] EC_NONE = 5'h00;
	localparam logic [4:0] EC_ERR  = 5'h02;
	localparam logic [4:0] EC_TX2  = 5'h04;
	localparam logic [4:0] EC_TX1  = 5'h06;
	localparam logic [4:0] EC_TX0  = 5'h08;
	localparam logic [4:0] EC_WAKE = 5'h0E;
	localparam logic [4:0] EC_RX0  = 5'h10;
	localparam logic [4:0] EC_RX1  = 5'h11;
	localparam logic [4:0] EC_PRG0 = 5'h12;

	typedef enum logic [2:0] {
		BUF_RX0, BUF_RX1, BUF_TX0, BUF_TX1, BUF_TX2
	} ccsr_buf_type;

	typedef enum logic {MS_FOLLOW, MS_WAIT_IDLE} ccsr_mstate_type;

	// pending interrupt sources from the message engine
	typedef struct packed {
		logic       err;
		logic       wake;
		logic       rx0;
		logic       rx1;
		logic       tx0;
		logic       tx1;
		logic       tx2;
		logic [5:0] prog;
	} ccsr_irq_type;

	// apb request signals from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} ccsr_apb_req_type;
endpackage
`default_nettype wire

// *** design/ccsr_top.sv ***
// Notes on behaviour
// R1: requested mode 1xx is config, 011 listen, 010 loopback, 001 disable, 000 normal.
// R2: current mode reads 100,011,010,001 or 000; codes 101 to 111 never appear.
// R3: software sets abort bit to abort all pending transmits; zero means normal.
// R4: legacy map select 101 rx1, 100 tx0, 011 tx1, 010 tx2.
// R5: legacy map select 111, 110, 001, 000 all map receive buffer zero.
// R6: map select windows the chosen buffer; legacy control bit 0 reads zero.
// R7: fifo variant shows read-only four-bit read pointer in control bits 3 to 0.
// R8: legacy source code values: none, error, tx2, tx1, tx0, rx1, rx0, wake.
// R9: only the highest-priority pending source is shown in the code field.
// R10: legacy source code sits in bits 3 to 1, aligned with map select.
// R11: enhanced variants use five-bit source codes in status bits 4 to 0.
// R12: programmable buffers 0 to 5 report codes 10010 to 10111.
// R13: fifo variant reports 10000 for any receiving buffer.
// R14: software translates enhanced codes itself before using them as map select.
// R15: config request waits for bus idle; other modes take effect at once.
// R16: software polls current mode until it matches the request.
// R17: software should request disable before putting the device to sleep.
// R18: interrupt handlers should save both registers on entry.
// R19: variant select 00 legacy (default), 01 enhanced, 10 fifo, 11 reserved.
// R20: variant writable only in config; takes effect after config is left.
// R21: reset: requested mode 100, current mode config, all else zero.
`default_nettype none
module ccsr_top (
	input  wire logic                       i_clk,
	input  wire logic                       i_sys_rst,
	input  wire ccsr_pkg::ccsr_apb_req_type i_apb,
	output logic [31:0]                     o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr,
	input  wire logic                       i_bus_idle,
	input  wire logic                       i_abort_done,
	input  wire ccsr_pkg::ccsr_irq_type     i_pend,
	input  wire logic [5:0]                 i_prog_rx,
	input  wire logic [3:0]                 i_fifo_ptr,
	output logic [2:0]                      o_cur_mode,
	output logic [1:0]                      o_variant,
	output logic                            o_abort_req,
	output ccsr_pkg::ccsr_buf_type          o_map_buf
);
	logic [2:0]                req_r;
	logic [2:0]                cur_r;
	logic [2:0]                cur_nxt;
	logic                      abort_r;
	logic [2:0]                win_r;
	logic [1:0]                var_sel_r;
	logic [1:0]                var_eff_r;
	logic [2:0]                icode_r;
	logic [4:0]                eicode_r;
	logic [2:0]                icode_c;
	logic [4:0]                eicode_c;
	logic [31:0]               prdata_r;
	ccsr_pkg::ccsr_buf_type    map_r;
	ccsr_pkg::ccsr_mstate_type ms_r;
	logic                      setup;
	logic                      access;
	logic                      wr_ctrl;
	logic                      wr_var;
	logic [7:0]                ctrl_val;
	logic [7:0]                stat_val;
	logic [7:0]                wbyte;

	// address decode, used only for the slave error response
	function automatic logic addr_ok(input logic [7:0] a);
		return a == ccsr_pkg::CTRL_OFS || a == ccsr_pkg::STAT_OFS
			|| a == ccsr_pkg::VAR_OFS;
	endfunction

	// legacy window decode; every unnamed code falls back to rx0
	function automatic ccsr_pkg::ccsr_buf_type win_dec(input logic [2:0] w);
		unique case (w)
			3'h5: return ccsr_pkg::BUF_RX1; // [R4]
			3'h4: return ccsr_pkg::BUF_TX0; // [R4]
			3'h3: return ccsr_pkg::BUF_TX1; // [R4]
			3'h2: return ccsr_pkg::BUF_TX2; // [R4]
			3'h7, 3'h6, 3'h1, 3'h0: return ccsr_pkg::BUF_RX0; // [R5]
		endcase
	endfunction

	// apb phases; zero wait states so the slave never stalls
	assign setup = i_apb.psel & ~i_apb.penable;
	assign access = i_apb.psel & i_apb.penable;
	assign o_pready = i_apb.penable;
	assign o_pslverr = access & ~addr_ok(i_apb.paddr);
	assign wbyte = i_apb.pwdata[7:0];
	assign wr_ctrl = access & i_apb.pwrite & (i_apb.paddr == ccsr_pkg::CTRL_OFS);
	assign wr_var = access & i_apb.pwrite & (i_apb.paddr == ccsr_pkg::VAR_OFS);

	// control readback depends on the variant in force
	always_comb begin
		ctrl_val = {req_r, abort_r, 4'h0};
		unique case (var_eff_r)
			ccsr_pkg::VAR_FIFO: ctrl_val[3:0] = i_fifo_ptr; // [R7]
			ccsr_pkg::VAR_ENH: ctrl_val[3:0] = 4'h0;
			default: ctrl_val[3:0] = {win_r, 1'b0}; // [R6]
		endcase
	end

	// status readback; legacy code shares bit lanes with the window
	always_comb begin
		stat_val = {cur_r, 5'h00};
		if (var_eff_r == ccsr_pkg::VAR_LEGACY) begin
			stat_val[3:1] = icode_r; // [R10]
		end else begin
			stat_val[4:0] = eicode_r; // [R11]
		end
	end

	// read data captured in setup so it comes from a flop in access
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup) begin
			unique case (i_apb.paddr)
				ccsr_pkg::CTRL_OFS: prdata_r <= {24'h00_0000, ctrl_val};
				ccsr_pkg::STAT_OFS: prdata_r <= {24'h00_0000, stat_val};
				ccsr_pkg::VAR_OFS: prdata_r <= {30'h0000_0000, var_sel_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end
	assign o_prdata = prdata_r;

	// requested mode; any code is legal, stored as written and decoded by the sequencer
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			req_r <= ccsr_pkg::REQ_RST; // [R21]
		end else if (wr_ctrl) begin
			req_r <= wbyte[ccsr_pkg::REQ_LSB +: 3]; // [R1]
		end
	end

	// mode sequencing: config waits for an idle bus, the rest follow at once
	always_comb begin
		cur_nxt = cur_r;
		if (req_r[2]) begin
			if (i_bus_idle) begin
				cur_nxt = ccsr_pkg::MODE_CONFIG; // [R15] [R1]
			end
		end else begin
			cur_nxt = req_r; // [R15]
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cur_r <= ccsr_pkg::CUR_RST; // [R21]
			ms_r <= ccsr_pkg::MS_FOLLOW;
		end else begin
			cur_r <= cur_nxt; // [R2]
			unique case (ms_r)
				ccsr_pkg::MS_FOLLOW:
					if (req_r[2] && !i_bus_idle && cur_r != ccsr_pkg::MODE_CONFIG) begin
						ms_r <= ccsr_pkg::MS_WAIT_IDLE;
					end
				ccsr_pkg::MS_WAIT_IDLE:
					if (!req_r[2] || i_bus_idle) begin
						ms_r <= ccsr_pkg::MS_FOLLOW;
					end
			endcase
		end
	end

	// abort: set only by software, dropped by the engine when done;
	// a set in the same cycle as the engine's clear wins
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			abort_r <= 1'b0;
		end else if (wr_ctrl && wbyte[ccsr_pkg::ABORT_BIT]) begin
			abort_r <= 1'b1; // [R3]
		end else if (i_abort_done) begin
			abort_r <= 1'b0;
		end
	end

	// window select is writable only in the legacy variant
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			win_r <= ccsr_pkg::WIN_RST;
		end else if (wr_ctrl && var_eff_r == ccsr_pkg::VAR_LEGACY) begin
			win_r <= wbyte[ccsr_pkg::WIN_LSB +: 3]; // [R6]
		end
	end

	// registered window decode drives the access bank mux
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			map_r <= ccsr_pkg::BUF_RX0;
		end else begin
			map_r <= win_dec(win_r); // [R4] [R5]
		end
	end

	// variant select: the reserved code is dropped to keep the field legal
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			var_sel_r <= ccsr_pkg::VAR_RST; // [R19]
		end else if (wr_var && cur_r == ccsr_pkg::MODE_CONFIG
				&& wbyte[1:0] != ccsr_pkg::VAR_RSVD) begin
			var_sel_r <= wbyte[ccsr_pkg::VAR_LSB +: 2]; // [R20]
		end
	end

	// new variant only applies on the edge that leaves config,
	// so the engine never sees it change mid-setup
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			var_eff_r <= ccsr_pkg::VAR_RST;
		end else if (cur_r == ccsr_pkg::MODE_CONFIG
				&& cur_nxt != ccsr_pkg::MODE_CONFIG) begin
			var_eff_r <= var_sel_r; // [R20]
		end
	end

	ccsr_irq_enc u_enc (
		.i_pend     (i_pend),
		.i_prog_rx  (i_prog_rx),
		.i_fifo_var (var_eff_r == ccsr_pkg::VAR_FIFO),
		.o_icode    (icode_c),
		.o_eicode   (eicode_c)
	);

	// codes registered once per cycle so a read sees one consistent value
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			icode_r <= ccsr_pkg::IC_NONE;
			eicode_r <= ccsr_pkg::EC_NONE;
		end else begin
			icode_r <= icode_c; // [R8] [R9]
			eicode_r <= eicode_c; // [R11] [R12]
		end
	end

	assign o_cur_mode = cur_r;
	assign o_variant = var_eff_r;
	assign o_abort_req = abort_r;
	assign o_map_buf = map_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	mode_follow_a: assert property (!req_r[2] |=> cur_r == $past(req_r)) // [R15]
		else $error("current mode did not follow request");
	cfg_wait_a: assert property ( // [R15]
		req_r[2] && !i_bus_idle && cur_r != ccsr_pkg::MODE_CONFIG
		|=> cur_r != ccsr_pkg::MODE_CONFIG)
		else $error("config entered while bus busy");
	cfg_enter_a: assert property (req_r[2] && i_bus_idle // [R1]
		|=> cur_r == ccsr_pkg::MODE_CONFIG)
		else $error("config not entered on idle bus");
	mode_legal_a: assert property (!(cur_r[2] && cur_r[1:0] != 2'h0)) // [R2]
		else $error("reserved current mode shown");
	abort_set_a: assert property ( // [R3]
		wr_ctrl && wbyte[ccsr_pkg::ABORT_BIT] |=> abort_r ##0 o_abort_req)
		else $error("abort not raised");
	abort_hold_a: assert property (abort_r && !i_abort_done |=> abort_r) // [R3]
		else $error("abort dropped early");
	var_lock_a: assert property (cur_r != ccsr_pkg::MODE_CONFIG // [R20]
		|=> $stable(var_sel_r))
		else $error("variant changed outside config");
	var_apply_a: assert property ( // [R20]
		$past(cur_r) == ccsr_pkg::MODE_CONFIG && cur_r != ccsr_pkg::MODE_CONFIG
		|-> var_eff_r == $past(var_sel_r))
		else $error("variant not applied on config exit");
	bit_zero_a: assert property (var_eff_r == ccsr_pkg::VAR_LEGACY // [R6]
		|-> ctrl_val[0] == 1'b0 && stat_val[0] == 1'b0)
		else $error("legacy bit 0 not zero");
	err_prio_a: assert property (i_pend.err |=> icode_r == ccsr_pkg::IC_ERR // [R9]
		&& eicode_r == ccsr_pkg::EC_ERR)
		else $error("error source not top priority");
	map_track_a: assert property (wr_ctrl && var_eff_r == ccsr_pkg::VAR_LEGACY // [R4]
		&& wbyte[3:1] == 3'h5 |=> ##1 o_map_buf == ccsr_pkg::BUF_RX1)
		else $error("window not mapped to rx1");

	cfg_wait_c: cover property (ms_r == ccsr_pkg::MS_WAIT_IDLE ##1 i_bus_idle);
	abort_c: cover property (abort_r ##[1:8] i_abort_done);
	fifo_c: cover property (var_eff_r == ccsr_pkg::VAR_FIFO && setup);
	var_chg_c: cover property ($changed(var_eff_r));
endmodule
`default_nettype wire

// *** sim/can_mode_status_regs_tb.sv ***
`default_nettype none
module can_mode_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] A_CT = ccsr_pkg::CTRL_OFS;
	localparam logic [7:0] A_ST = ccsr_pkg::STAT_OFS;
	localparam logic [7:0] A_VR = ccsr_pkg::VAR_OFS;
	// legacy codes, highest pending first: err, wake, rx0, rx1, tx0, tx1, tx2
	localparam logic [2:0] LEG_CODE [7] = '{3'h1, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2};
	// enhanced codes in the same order, then programmable buffers 0 to 5
	localparam logic [4:0] ENH_CODE [13] = '{5'h02, 5'h0E, 5'h10, 5'h11, 5'h08, 5'h06,
		5'h04, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17};
	// window value to mapped buffer, enum order rx0 rx1 tx0 tx1 tx2
	localparam logic [2:0] MAP_EXP [8] = '{3'h0, 3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};

	logic                       i_clk;
	logic                       i_sys_rst;
	ccsr_pkg::ccsr_apb_req_type i_apb;
	logic [31:0]                o_prdata;
	logic                       o_pready;
	logic                       o_pslverr;
	logic                       i_bus_idle;
	logic                       i_abort_done;
	ccsr_pkg::ccsr_irq_type     i_pend;
	logic [5:0]                 i_prog_rx;
	logic [3:0]                 i_fifo_ptr;
	logic [2:0]                 o_cur_mode;
	logic [1:0]                 o_variant;
	logic                       o_abort_req;
	ccsr_pkg::ccsr_buf_type     o_map_buf;
	int                         bad_count;
	int                         samples_checked;
	logic [31:0]                rdata;
	logic                       err_seen;

	ccsr_top dut (.*);

	// free-running clock, 20 ns period
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	// a run still going after 20000 cycles ends here; xfer times out a hung handshake itself after 50
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		end_sim();
	end

	task automatic end_sim();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge i_clk);
		i_apb.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		// a slave that never answers counts as a mismatch
		if (n >= 50) begin
			bad_count++;
		end
		rdata = o_prdata;
		err_seen = o_pslverr;
		i_apb.psel <= 1'b0;
		i_apb.penable <= 1'b0;
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(what, e, rdata);
	endtask

	// variant change goes through config with the bus idle
	task automatic set_var(input logic [1:0] v);
		int n;
		xfer(1'b1, A_CT, 32'h80);
		// poll the current mode instead of trusting a fixed delay
		n = 0;
		do begin
			xfer(1'b0, A_ST, 32'h0);
			n++;
		end while (rdata[7:5] !== 3'h4 && n < 20);
		chk("cfg poll", 32'h4, {29'h0, rdata[7:5]});
		xfer(1'b1, A_VR, {30'h0, v});
		xfer(1'b1, A_CT, 32'h0);
		repeat (2) @(posedge i_clk);
	endtask

	task automatic t_modes();
		for (int m = 3; m >= 0; m--) begin
			xfer(1'b1, A_CT, 32'(m << 5));
			rdc("mode", A_ST, 32'(m << 5));
		end
		// disable is requested before the device is put to sleep
		xfer(1'b1, A_CT, 32'h20);
		rdc("disable", A_ST, 32'h20);
		// busy bus must hold the config request back
		xfer(1'b1, A_CT, 32'hE0);
		repeat (4) @(posedge i_clk);
		chk("cfg held", 32'h1, {29'h0, o_cur_mode});
		i_bus_idle <= 1'b1;
		repeat (3) @(posedge i_clk);
		rdc("cfg idle", A_ST, 32'h80);
		rdc("req back", A_CT, 32'hE0);
	endtask

	task automatic t_variant();
		xfer(1'b1, A_VR, 32'h1);
		rdc("var wr", A_VR, 32'h1);
		chk("var held", 32'h0, {30'h0, o_variant});
		xfer(1'b1, A_VR, 32'h3);
		rdc("var rsvd", A_VR, 32'h1);
		xfer(1'b1, A_CT, 32'h0);
		repeat (2) @(posedge i_clk);
		chk("var live", 32'h1, {30'h0, o_variant});
		xfer(1'b1, A_VR, 32'h2);
		rdc("var lock", A_VR, 32'h1);
		set_var(2'h0);
	endtask

	task automatic t_window();
		for (int w = 0; w < 8; w++) begin
			xfer(1'b1, A_CT, 32'(w * 2 + 1));
			rdc("window", A_CT, 32'(w * 2));
			chk("map", {29'h0, MAP_EXP[w]}, {29'h0, o_map_buf});
		end
	endtask

	task automatic t_abort();
		xfer(1'b1, A_CT, 32'h10);
		rdc("abort set", A_CT, 32'h10);
		xfer(1'b1, A_CT, 32'h0);
		chk("abort kept", 32'h1, {31'h0, o_abort_req});
		i_abort_done <= 1'b1;
		@(posedge i_clk);
		i_abort_done <= 1'b0;
		rdc("abort clr", A_CT, 32'h0);
	endtask

	// every lower-priority source stays pending under the one expected, save the programmable buffers in the legacy loop
	task automatic t_codes();
		for (int k = 0; k < 7; k++) begin
			i_pend <= {7'h7F >> k, 6'h00};
			rdc("icode", A_ST, {28'h0, LEG_CODE[k], 1'b0});
		end
		// handler saves both registers, copies the code into the window, restores
		i_pend <= {7'h08, 6'h00};
		rdc("isr ctrl", A_CT, 32'h0);
		rdc("isr stat", A_ST, 32'hA);
		xfer(1'b1, A_CT, rdata & 32'hE);
		repeat (2) @(posedge i_clk);
		chk("icode map", 32'h1, {29'h0, o_map_buf});
		xfer(1'b1, A_CT, 32'h0);
		i_pend <= '0;
		rdc("icode none", A_ST, 32'h0);
		set_var(2'h1);
		// enhanced codes are only compared here, never copied into a window
		for (int k = 0; k < 13; k++) begin
			if (k < 7) begin
				i_pend <= 13'h1FFF >> k;
			end else begin
				i_pend <= {7'h00, 6'(6'h3F << (k - 7))};
			end
			rdc("ecode", A_ST, {27'h0, ENH_CODE[k]});
		end
		i_pend <= '0;
		rdc("ecode none", A_ST, 32'h0);
	endtask

	task automatic t_fifo();
		set_var(2'h2);
		i_prog_rx <= 6'h3F;
		i_fifo_ptr <= 4'h7;
		rdc("fifo ptr", A_CT, 32'h7);
		for (int j = 0; j < 10; j++) begin
			i_pend <= 13'h1 << ((j > 5) ? 9 : j);
			rdc("fifo rx", A_ST, 32'h10);
		end
		i_pend <= '0;
		xfer(1'b1, A_ST, 32'hFF);
		rdc("stat ro", A_ST, 32'h0);
		xfer(1'b0, 8'h0C, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err_seen});
		chk("unmapped data", 32'h0, rdata);
	endtask

	// main sequence
	initial begin
		bad_count = 0;
		samples_checked = 0;
		i_sys_rst = 1'b1;
		i_apb = '0;
		i_bus_idle = 1'b0;
		i_abort_done = 1'b0;
		i_pend = '0;
		i_prog_rx = 6'h0;
		i_fifo_ptr = 4'h0;
		repeat (5) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rdc("ctrl rst", A_CT, 32'h80);
		rdc("stat rst", A_ST, 32'h80);
		rdc("var rst", A_VR, 32'h0);
		chk("map rst", 32'h0, {29'h0, o_map_buf});
		t_modes();
		t_variant();
		t_window();
		t_abort();
		t_codes();
		t_fifo();
		end_sim();
	end
endmodule
`default_nettype wire
